/* File: bench/smcr_host.sv */
// Host controller model driving the register port
module smcr_host (input wire mclk, output logic [5:0] reg_addr, output logic reg_wr,
    output logic [7:0] reg_wdata, input wire [7:0] reg_rdata);
    timeunit 1ns; timeprecision 1ps;
    initial begin reg_addr = 6'h00; reg_wr = 1'b0; reg_wdata = 8'h00; end
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(negedge mclk); reg_addr = a; reg_wdata = d; reg_wr = 1'b1;
        @(negedge mclk); reg_wr = 1'b0; reg_wdata = ~d; // Stale data is not held
    endtask
    task automatic rd(input logic [5:0] a, output logic [7:0] d);
        @(negedge mclk); reg_addr = a;
        @(negedge mclk); d = reg_rdata;
    endtask
endmodule // smcr_host

/* File: bench/smcr_properties.sv */
// Checker for the configuration register group
module smcr_properties #(parameter WORD_W = 40) (
    input wire mclk, input wire srst, input wire [5:0] reg_addr, input wire reg_wr,
    input wire [7:0] reg_wdata, input wire [7:0] reg_rdata, input wire rx_active,
    input wire [WORD_W-1:0] synth_carrier_word_word, input wire [WORD_W-1:0] mixer_if_word,
    input wire [WORD_W-1:0] symbol_rate_word, input wire [8:0] decim_ratio,
    input wire [1:0] filter_width_exp, input wire [1:0] filter_width_mant);
    // Outputs lag reset release by one edge, so hold off checks
    reg [1:0] up_reg;
    always @(posedge mclk) up_reg <= srst ? 2'h0 : up_reg + {1'b0, ~&up_reg};
    default clocking @(posedge mclk); endclocking
    default disable iff (srst);
    sequence s_rel; srst ##1 (!srst && !reg_wr && !rx_active)[*2]; endsequence
    sequence s_rx; &up_reg && !reg_wr && !$past(reg_wr); endsequence
    top_bits_a: assert property (&up_reg && ($past(reg_addr) == 6'h0B || $past(reg_addr) == 6'h0D)
        |-> reg_rdata[7:6] == 2'h0) else $error("unused bits read nonzero");
    mixer_if_a: assert property (&up_reg |-> mixer_if_word[17:0] == 18'h0
        && (mixer_if_word >> 23) == 0) else $error("mixer word out of form");
    rate_form_a: assert property (&up_reg |-> symbol_rate_word >= 40'h100
        && symbol_rate_word < 40'h1000000) else $error("rate word out of range");
    decim_a: assert property (&up_reg ##0 $stable({filter_width_exp, filter_width_mant})[*2]
        |-> decim_ratio == 9'((9'h004 + filter_width_mant) << 3 << filter_width_exp))
        else $error("decimation mismatch");
    rx_sub_a: assert property (s_rx ##0 $rose(rx_active) |=>
        synth_carrier_word_word == $past(synth_carrier_word_word) - mixer_if_word) else $error("IF not removed");
    rx_add_a: assert property (s_rx ##0 $fell(rx_active) |=>
        synth_carrier_word_word == $past(synth_carrier_word_word) + mixer_if_word) else $error("IF not restored");
    rst_val_a: assert property (disable iff (1'b0) s_rel |=> mixer_if_word == 40'h3C0000
        && symbol_rate_word == 40'h122000 && decim_ratio == 9'h080)
        else $error("reset words wrong");
    rst_carrier_a: assert property (disable iff (1'b0) s_rel |=>
        synth_carrier_word_word == 40'h1EC4EC000) else $error("reset carrier wrong");
endmodule // smcr_properties
bind smcr_regs smcr_properties #(.WORD_W(WORD_W)) i_props (.mclk(mclk), .srst(srst),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .rx_active(rx_active), .synth_carrier_word_word(synth_carrier_word_word), .mixer_if_word(mixer_if_word),
    .symbol_rate_word(symbol_rate_word), .decim_ratio(decim_ratio),
    .filter_width_exp(filter_width_exp), .filter_width_mant(filter_width_mant));

/* File: bench/smcr_regs_tb_top.sv */
// Self-checking bench for the configuration register group
module smcr_regs_tb_top;
    timeunit 1ns; timeprecision 1ps;
    logic mclk = 1'b0, srst = 1'b1, rx_active = 1'b0, reg_wr;
    logic [5:0] reg_addr, a;
    logic [7:0] reg_wdata, reg_rdata, d;
    logic [8:0] decim_ratio;
    logic [39:0] synth_carrier_word_word, mixer_if_word, symbol_rate_word;
    logic [1:0] filter_width_exp, filter_width_mant;
    logic [7:0] sh [11:17];
    int bad_count = 0, check_count = 0, cyc = 0;
    always #10 mclk = ~mclk;
    smcr_regs #(.WORD_W(40)) i_dut (.mclk(mclk), .srst(srst), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .rx_active(rx_active),
        .synth_carrier_word_word(synth_carrier_word_word), .mixer_if_word(mixer_if_word),
        .symbol_rate_word(symbol_rate_word), .decim_ratio(decim_ratio),
        .filter_width_exp(filter_width_exp), .filter_width_mant(filter_width_mant));
    smcr_host i_host (.mclk(mclk), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
    task chk(input string n, input logic [39:0] s, input logic [39:0] e);
        check_count++;
        if (s !== e) begin bad_count++; $display("[FAIL] %s exp %h seen %h", n, e, s); end
    endtask
    task end_of_test;
        $display("errors %0d checks %0d", bad_count, check_count);
        if (bad_count == 0 && check_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    function logic [7:0] rexp(input logic [5:0] x);
        return (x < 6'h0B || x > 6'h11) ? 8'h00 : sh[x];
    endfunction
    function logic [39:0] sfw();
        return ({18'h0, sh[13][5:0], sh[14], sh[15]} << 12) + ({{32{sh[12][7]}}, sh[12]} << 14)
            - (rx_active ? {35'h0, sh[11][4:0]} << 18 : 40'h0);
    endfunction
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 4000) begin bad_count++; end_of_test; end
    end
    initial begin
        void'($urandom(32'h6B9EEB5C));
        sh = '{8'h0F, 8'h00, 8'h1E, 8'hC4, 8'hEC, 8'h8C, 8'h22};
        repeat (16) @(negedge mclk);
        srst = 1'b0;
        for (int i = 10; i < 19; i++) begin
            i_host.rd(6'(i), d);
            chk("reset", d, rexp(6'(i)));
        end
        // Corner writes of all ones first, then random traffic incl. unmapped
        for (int i = 0; i < 80; i++) begin
            a = (i < 2) ? (i ? 6'h0D : 6'h0B) : 6'($urandom_range(10, 18));
            d = (i < 2) ? 8'hFF : 8'($urandom);
            rx_active = 1'($urandom);
            i_host.wr(a, d);
            if (a > 6'h0A && a < 6'h12) sh[a] = d & ((a == 6'h0B || a == 6'h0D) ? 8'h3F : 8'hFF);
            i_host.rd(a, d);
            chk("read", d, rexp(a));
            chk("synth", synth_carrier_word_word, sfw());
            chk("mixer", mixer_if_word, {35'h0, sh[11][4:0]} << 18);
            chk("rate", symbol_rate_word, (40'h100 + sh[17]) << sh[16][3:0]);
            chk("decim", decim_ratio, 9'((9'h004 + sh[16][5:4]) << 3 << sh[16][7:6]));
            chk("bw", {filter_width_exp, filter_width_mant}, sh[16][7:4]);
        end
        end_of_test;
    end
endmodule // smcr_regs_tb_top

/* File: hw/smcr_consts.vh */
// Constants for the synthesizer and modem configuration register group
`ifndef SMCR_CONSTS_VH
`define SMCR_CONSTS_VH
// ----------------------------------------
// Register addresses
// ----------------------------------------
`define SMCR_ADDR_IF_CTRL 6'h0B
`define SMCR_ADDR_OFFSET 6'h0C
`define SMCR_ADDR_CW_HIGH 6'h0D
`define SMCR_ADDR_CW_MID 6'h0E
`define SMCR_ADDR_CW_LOW 6'h0F
`define SMCR_ADDR_FW_EXP 6'h10
`define SMCR_ADDR_SR_MANT 6'h11
// ----------------------------------------
// Reset values
// ----------------------------------------
`define SMCR_RST_IF_CTRL 8'h0F
`define SMCR_RST_OFFSET 8'h00
`define SMCR_RST_CW_HIGH 8'h1E
`define SMCR_RST_CW_MID 8'hC4
`define SMCR_RST_CW_LOW 8'hEC
`define SMCR_RST_FW_EXP 8'h8C
`define SMCR_RST_SR_MANT 8'h22
// ----------------------------------------
// Field masks and scaling shifts
// ----------------------------------------
`define SMCR_MASK_IF_CTRL 8'h3F
`define SMCR_MASK_CW_HIGH 8'h3F
`define SMCR_SHIFT_IF 10
`define SMCR_SHIFT_OFFSET 14
`define SMCR_SHIFT_CARRIER 16
`define SMCR_SHIFT_RATE 28
`define SMCR_HIDDEN_ONE 9'h100
`define SMCR_BW_BASE 5'h04
`define SMCR_BW_SCALE_SHIFT 3
// ----------------------------------------
// Field positions
// ----------------------------------------
`define SMCR_IF_SEL_RANGE 4:0
`define SMCR_CW_HIGH_RANGE 5:0
`define SMCR_FW_EXP_RANGE 7:6
`define SMCR_FW_MANT_RANGE 5:4
`define SMCR_SR_EXP_RANGE 3:0
`endif

/* File: hw/smcr_regs.v */
// Synthesizer and modem configuration registers with derived control words
`include "smcr_consts.vh"

module smcr_regs #(
    parameter WORD_W = 40
) (
    // Clock and reset
    input wire mclk,
    input wire srst,
    // Register port
    input wire [5:0] reg_addr,
    input wire reg_wr,
    input wire [7:0] reg_wdata,
    output reg [7:0] reg_rdata,
    // Radio state
    input wire rx_active,
    // Derived synthesizer words, oscillator-relative, scaled by 2^28
    output reg [WORD_W-1:0] synth_carrier_word_word,
    output reg [WORD_W-1:0] mixer_if_word,
    output reg [WORD_W-1:0] symbol_rate_word,
    // Channel filter decimation: 8*(4+mant)*2^exp
    output reg [8:0] decim_ratio,
    output reg [1:0] filter_width_exp,
    output reg [1:0] filter_width_mant
);

// ----------------------------------------
// Address decode
// ----------------------------------------
// Slots of the one-hot register select
localparam SEL_IF = 0;
localparam SEL_OFF = 1;
localparam SEL_CWH = 2;
localparam SEL_CWM = 3;
localparam SEL_CWL = 4;
localparam SEL_FW = 5;
localparam SEL_SR = 6;
localparam SEL_N = 7;

// Shared by write and read paths so both always see one map
function [SEL_N-1:0] smcr_decode;
    input [5:0] addr;
    begin
        smcr_decode = {SEL_N{1'b0}};
        smcr_decode[SEL_IF] = (addr == `SMCR_ADDR_IF_CTRL);
        smcr_decode[SEL_OFF] = (addr == `SMCR_ADDR_OFFSET);
        smcr_decode[SEL_CWH] = (addr == `SMCR_ADDR_CW_HIGH);
        smcr_decode[SEL_CWM] = (addr == `SMCR_ADDR_CW_MID);
        smcr_decode[SEL_CWL] = (addr == `SMCR_ADDR_CW_LOW);
        smcr_decode[SEL_FW] = (addr == `SMCR_ADDR_FW_EXP);
        smcr_decode[SEL_SR] = (addr == `SMCR_ADDR_SR_MANT);
    end
endfunction

wire [SEL_N-1:0] rd_sel = smcr_decode(reg_addr);
// Unmapped addresses select nothing, so writes there vanish
wire [SEL_N-1:0] wr_sel = rd_sel & {SEL_N{reg_wr}};

// ----------------------------------------
// Register storage
// ----------------------------------------
reg [7:0] synth_if_ctrl_reg;
reg [7:0] synth_offset_ctrl_reg;
reg [7:0] carrier_word_high_reg;
reg [7:0] carrier_word_mid_reg;
reg [7:0] carrier_word_low_reg;
reg [7:0] filter_width_rate_exp_reg;
reg [7:0] symbol_rate_mant_reg;

reg [7:0] synth_if_ctrl_next;
reg [7:0] synth_offset_ctrl_next;
reg [7:0] carrier_word_high_next;
reg [7:0] carrier_word_mid_next;
reg [7:0] carrier_word_low_next;
reg [7:0] filter_width_rate_exp_next;
reg [7:0] symbol_rate_mant_next;

always @* begin
    synth_if_ctrl_next = synth_if_ctrl_reg;
    synth_offset_ctrl_next = synth_offset_ctrl_reg;
    carrier_word_high_next = carrier_word_high_reg;
    carrier_word_mid_next = carrier_word_mid_reg;
    carrier_word_low_next = carrier_word_low_reg;
    filter_width_rate_exp_next = filter_width_rate_exp_reg;
    symbol_rate_mant_next = symbol_rate_mant_reg;
    // Bits 7:6 of the IF control and carrier high registers are dropped on the way in, so reads need no masking
    if (wr_sel[SEL_IF]) begin
        synth_if_ctrl_next = reg_wdata & `SMCR_MASK_IF_CTRL;
    end
    if (wr_sel[SEL_OFF]) begin
        synth_offset_ctrl_next = reg_wdata;
    end
    if (wr_sel[SEL_CWH]) begin
        carrier_word_high_next = reg_wdata & `SMCR_MASK_CW_HIGH;
    end
    if (wr_sel[SEL_CWM]) begin
        carrier_word_mid_next = reg_wdata;
    end
    if (wr_sel[SEL_CWL]) begin
        carrier_word_low_next = reg_wdata;
    end
    if (wr_sel[SEL_FW]) begin
        filter_width_rate_exp_next = reg_wdata;
    end
    if (wr_sel[SEL_SR]) begin
        symbol_rate_mant_next = reg_wdata;
    end
end

always @(posedge mclk) begin
    if (srst) begin
        synth_if_ctrl_reg <= `SMCR_RST_IF_CTRL;
        synth_offset_ctrl_reg <= `SMCR_RST_OFFSET;
        carrier_word_high_reg <= `SMCR_RST_CW_HIGH;
        carrier_word_mid_reg <= `SMCR_RST_CW_MID;
        carrier_word_low_reg <= `SMCR_RST_CW_LOW;
        filter_width_rate_exp_reg <= `SMCR_RST_FW_EXP;
        symbol_rate_mant_reg <= `SMCR_RST_SR_MANT;
    end else begin
        synth_if_ctrl_reg <= synth_if_ctrl_next;
        synth_offset_ctrl_reg <= synth_offset_ctrl_next;
        carrier_word_high_reg <= carrier_word_high_next;
        carrier_word_mid_reg <= carrier_word_mid_next;
        carrier_word_low_reg <= carrier_word_low_next;
        filter_width_rate_exp_reg <= filter_width_rate_exp_next;
        symbol_rate_mant_reg <= symbol_rate_mant_next;
    end
end

// ----------------------------------------
// Read mux
// ----------------------------------------
reg [7:0] reg_rdata_next;
always @* begin
    reg_rdata_next = 8'h00;
    if (rd_sel[SEL_IF]) begin
        reg_rdata_next = synth_if_ctrl_reg;
    end
    if (rd_sel[SEL_OFF]) begin
        reg_rdata_next = synth_offset_ctrl_reg;
    end
    if (rd_sel[SEL_CWH]) begin
        reg_rdata_next = carrier_word_high_reg;
    end
    if (rd_sel[SEL_CWM]) begin
        reg_rdata_next = carrier_word_mid_reg;
    end
    if (rd_sel[SEL_CWL]) begin
        reg_rdata_next = carrier_word_low_reg;
    end
    if (rd_sel[SEL_FW]) begin
        reg_rdata_next = filter_width_rate_exp_reg;
    end
    if (rd_sel[SEL_SR]) begin
        reg_rdata_next = symbol_rate_mant_reg;
    end
end

// ----------------------------------------
// Derived words, all but the decimation ratio in units of f_osc / 2^28
// ----------------------------------------
// Common scale keeps base, offset and IF directly addable
wire [23:0] carrier_word = {carrier_word_high_reg[`SMCR_CW_HIGH_RANGE], carrier_word_mid_reg,
    carrier_word_low_reg};
wire [4:0] if_select = synth_if_ctrl_reg[`SMCR_IF_SEL_RANGE];
wire signed [7:0] synth_offset = synth_offset_ctrl_reg;
wire [3:0] symbol_rate_exp = filter_width_rate_exp_reg[`SMCR_SR_EXP_RANGE];
wire [1:0] fw_exp_field = filter_width_rate_exp_reg[`SMCR_FW_EXP_RANGE];
wire [1:0] fw_mant_field = filter_width_rate_exp_reg[`SMCR_FW_MANT_RANGE];

wire signed [WORD_W:0] base_term = $signed({1'b0, {{(WORD_W-24){1'b0}}, carrier_word}})
    <<< (`SMCR_SHIFT_RATE - `SMCR_SHIFT_CARRIER);
wire signed [WORD_W:0] offset_term = {{(WORD_W-7){synth_offset[7]}}, synth_offset}
    <<< (`SMCR_SHIFT_RATE - `SMCR_SHIFT_OFFSET);
wire signed [WORD_W:0] if_term = $signed({1'b0, {{(WORD_W-5){1'b0}}, if_select}})
    <<< (`SMCR_SHIFT_RATE - `SMCR_SHIFT_IF);
wire signed [WORD_W:0] synth_sum = base_term + offset_term - (rx_active ? if_term :
    {(WORD_W+1){1'b0}});
// Hidden leading one makes a 9-bit mantissa
wire [8:0] rate_mant9 = `SMCR_HIDDEN_ONE | {1'b0, symbol_rate_mant_reg};
wire [WORD_W-1:0] rate_word = {{(WORD_W-9){1'b0}}, rate_mant9} << symbol_rate_exp;
wire [4:0] bw_div = `SMCR_BW_BASE + {3'b000, fw_mant_field};
// Largest ratio is 448, so nine bits are needed to hold it
wire [8:0] decim_next = ({4'h0, bw_div} << `SMCR_BW_SCALE_SHIFT) << fw_exp_field;

always @(posedge mclk) begin
    if (srst) begin
        reg_rdata <= 8'h00;
        synth_carrier_word_word <= {WORD_W{1'b0}};
        mixer_if_word <= {WORD_W{1'b0}};
        symbol_rate_word <= {WORD_W{1'b0}};
        decim_ratio <= 9'h000;
        filter_width_exp <= 2'h0;
        filter_width_mant <= 2'h0;
    end else begin
        reg_rdata <= reg_rdata_next;
        synth_carrier_word_word <= synth_sum[WORD_W-1:0];
        mixer_if_word <= if_term[WORD_W-1:0];
        symbol_rate_word <= rate_word;
        decim_ratio <= decim_next;
        filter_width_exp <= fw_exp_field;
        filter_width_mant <= fw_mant_field;
    end
end

endmodule // smcr_regs
